// File: hw/boundary_scan_tap_consts.svh
// Constants for the boundary-scan test access port
`ifndef BOUNDARY_SCAN_TAP_CONSTS_SVH
`define BOUNDARY_SCAN_TAP_CONSTS_SVH
// ----------------------------------------
// Sizes
// ----------------------------------------
`define BST_PIN_COUNT 4
`define BST_CHAIN_LEN 8
`define BST_IR_LEN 4
`define BST_ID_LEN 32
// ----------------------------------------
// Instruction codes
// ----------------------------------------
`define BST_INS_EXTEST 4'h0
`define BST_INS_SAMPLE 4'h1
`define BST_INS_IDCODE 4'h2
`define BST_INS_CLAMP 4'h3
`define BST_INS_HIGHZ 4'h4
`define BST_INS_BYPASS 4'hf
// Fixed pattern loaded into the instruction shift stage on capture
`define BST_IR_CAPTURE 4'h1
// ----------------------------------------
// Identity word fields (values are arbitrary)
// ----------------------------------------
`define BST_ID_VERSION 4'h1
`define BST_ID_PART 16'h0123
`define BST_ID_MAKER 11'h055
`define BST_ID_FIXED 1'h1
`endif

// File: hw/boundary_scan_tap_pkg.sv
// Types shared by the boundary-scan test access port
package boundary_scan_tap_pkg;
	// Controller states, one-hot
	typedef enum logic [15:0] {
		ST_RESET = 16'h0001,
		ST_IDLE = 16'h0002,
		ST_SEL_DR = 16'h0004,
		ST_CAP_DR = 16'h0008,
		ST_SH_DR = 16'h0010,
		ST_EX1_DR = 16'h0020,
		ST_PAU_DR = 16'h0040,
		ST_EX2_DR = 16'h0080,
		ST_UPD_DR = 16'h0100,
		ST_SEL_IR = 16'h0200,
		ST_CAP_IR = 16'h0400,
		ST_SH_IR = 16'h0800,
		ST_EX1_IR = 16'h1000,
		ST_PAU_IR = 16'h2000,
		ST_EX2_IR = 16'h4000,
		ST_UPD_IR = 16'h8000
	} tap_state_t;
endpackage : boundary_scan_tap_pkg

// File: hw/boundary_scan_tap.sv
// Boundary-scan test access port with boundary cells on the device pins
`timescale 1ns/1ps
`include "boundary_scan_tap_consts.svh"

module boundary_scan_tap (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	output logic tdo,
	output logic tdo_oe,
	input wire logic [`BST_PIN_COUNT-1:0] core_out,
	input wire logic [`BST_PIN_COUNT-1:0] core_oe,
	output logic [`BST_PIN_COUNT-1:0] core_in,
	input wire logic [`BST_PIN_COUNT-1:0] pin_in,
	output logic [`BST_PIN_COUNT-1:0] pin_out,
	output logic [`BST_PIN_COUNT-1:0] pin_oe
);
	import boundary_scan_tap_pkg::*;

	// ----------------------------------------
	// Next-state function of the controller
	// ----------------------------------------
	function automatic tap_state_t tap_next(input tap_state_t s, input logic m);
		case (s)
			ST_RESET: tap_next = m ? ST_RESET : ST_IDLE;
			ST_IDLE: tap_next = m ? ST_SEL_DR : ST_IDLE;
			ST_SEL_DR: tap_next = m ? ST_SEL_IR : ST_CAP_DR;
			ST_CAP_DR: tap_next = m ? ST_EX1_DR : ST_SH_DR;
			ST_SH_DR: tap_next = m ? ST_EX1_DR : ST_SH_DR;
			ST_EX1_DR: tap_next = m ? ST_UPD_DR : ST_PAU_DR;
			ST_PAU_DR: tap_next = m ? ST_EX2_DR : ST_PAU_DR;
			ST_EX2_DR: tap_next = m ? ST_UPD_DR : ST_SH_DR;
			ST_UPD_DR: tap_next = m ? ST_SEL_DR : ST_IDLE;
			ST_SEL_IR: tap_next = m ? ST_RESET : ST_CAP_IR;
			ST_CAP_IR: tap_next = m ? ST_EX1_IR : ST_SH_IR;
			ST_SH_IR: tap_next = m ? ST_EX1_IR : ST_SH_IR;
			ST_EX1_IR: tap_next = m ? ST_UPD_IR : ST_PAU_IR;
			ST_PAU_IR: tap_next = m ? ST_EX2_IR : ST_PAU_IR;
			ST_EX2_IR: tap_next = m ? ST_UPD_IR : ST_SH_IR;
			ST_UPD_IR: tap_next = m ? ST_SEL_DR : ST_IDLE;
			default: tap_next = ST_RESET;
		endcase
	endfunction : tap_next

	// ----------------------------------------
	// Test clock domain: controller
	// ----------------------------------------
	tap_state_t state; // Controller state
	tap_state_t next_state; // State after the coming rising edge
	assign next_state = tap_next(state, tms);

	// Advance on each rising test-clock edge only
	always_ff @(posedge tck or posedge rst) begin
		if (rst) begin
			state <= ST_RESET;
		end else begin
			state <= next_state;
		end
	end

	// State decodes
	wire logic in_reset = (state == ST_RESET);
	wire logic cap_dr = (state == ST_CAP_DR);
	wire logic sh_dr = (state == ST_SH_DR);
	wire logic upd_dr = (state == ST_UPD_DR);
	wire logic cap_ir = (state == ST_CAP_IR);
	wire logic sh_ir = (state == ST_SH_IR);
	wire logic upd_ir = (state == ST_UPD_IR);

	// ----------------------------------------
	// Instruction register
	// ----------------------------------------
	logic [`BST_IR_LEN-1:0] ir_shift; // Shift stage
	logic [`BST_IR_LEN-1:0] ir; // Active instruction

	// Capture, shift and update of the instruction
	always_ff @(posedge tck or posedge rst) begin
		if (rst) begin
			ir_shift <= `BST_IR_CAPTURE;
			ir <= `BST_INS_IDCODE;
		end else begin
			if (in_reset) begin
				ir <= `BST_INS_IDCODE;
			end else if (upd_ir) begin
				ir <= ir_shift;
			end
			if (cap_ir) begin
				ir_shift <= `BST_IR_CAPTURE;
			end else if (sh_ir) begin
				ir_shift <= {tdi, ir_shift[`BST_IR_LEN-1:1]};
			end
		end
	end

	// Instruction decode; unknown codes behave as bypass
	wire logic ins_extest = (ir == `BST_INS_EXTEST);
	wire logic ins_sample = (ir == `BST_INS_SAMPLE);
	wire logic ins_idcode = (ir == `BST_INS_IDCODE);
	wire logic ins_clamp = (ir == `BST_INS_CLAMP);
	wire logic ins_highz = (ir == `BST_INS_HIGHZ);
	wire logic sel_chain = ins_extest | ins_sample;
	wire logic sel_id = ins_idcode;
	wire logic sel_bypass = ~sel_chain & ~sel_id;
	wire logic drive_mode = ins_extest | ins_clamp;

	// Mode flags held in flops, so the crossing never sees a decode glitch
	logic drive_flag; // Drive mode on the test clock
	logic highz_flag; // High-impedance mode on the test clock
	always_ff @(posedge tck or posedge rst) begin
		if (rst) begin
			drive_flag <= 1'h0;
			highz_flag <= 1'h0;
		end else begin
			drive_flag <= drive_mode;
			highz_flag <= ins_highz;
		end
	end

	// ----------------------------------------
	// Pin and core samples for capture
	// ----------------------------------------
	logic [`BST_PIN_COUNT-1:0] pin_meta; // First stage, read only by pin_seen
	logic [`BST_PIN_COUNT-1:0] pin_seen; // Pin level on the test clock
	logic [`BST_PIN_COUNT-1:0] core_meta; // First stage, read only by core_seen
	logic [`BST_PIN_COUNT-1:0] core_seen; // Core output on the test clock

	// Bring pins and core outputs into the test clock domain
	always_ff @(posedge tck or posedge rst) begin
		if (rst) begin
			pin_meta <= '0;
			pin_seen <= '0;
			core_meta <= '0;
			core_seen <= '0;
		end else begin
			pin_meta <= pin_in;
			pin_seen <= pin_meta;
			core_meta <= core_out;
			core_seen <= core_meta;
		end
	end

	// ----------------------------------------
	// Data registers
	// ----------------------------------------
	logic [`BST_CHAIN_LEN-1:0] boundary_cell_chain; // Even bit in cell, odd bit out cell
	logic [`BST_PIN_COUNT-1:0] out_update; // Update stage of the out cells only
	logic [`BST_ID_LEN-1:0] id_shift; // Identity shift stage
	logic passthrough_flop; // Single-bit passthrough

	// Identity word and capture image of the chain
	wire logic [`BST_ID_LEN-1:0] part_identity_word =
		{`BST_ID_VERSION, `BST_ID_PART, `BST_ID_MAKER, `BST_ID_FIXED};
	logic [`BST_CHAIN_LEN-1:0] chain_capture;
	always_comb begin
		chain_capture = '0;
		for (int i = 0; i < `BST_PIN_COUNT; i++) begin
			chain_capture[2*i] = pin_seen[i];
			chain_capture[2*i+1] = core_seen[i];
		end
	end

	// Boundary chain capture and shift
	always_ff @(posedge tck or posedge rst) begin
		if (rst) begin
			boundary_cell_chain <= '0;
		end else if (sel_chain && cap_dr) begin
			boundary_cell_chain <= chain_capture;
		end else if (sel_chain && sh_dr) begin
			boundary_cell_chain <= {tdi, boundary_cell_chain[`BST_CHAIN_LEN-1:1]};
		end
	end

	// Out cell update stage; in cells have none. The toggle announces each new
	// word to the system clock, which copies the word while it stands still.
	logic upd_toggle; // Flips once per update of the out cells
	always_ff @(posedge tck or posedge rst) begin
		if (rst) begin
			out_update <= '0;
			upd_toggle <= 1'h0;
		end else if (sel_chain && upd_dr) begin
			for (int i = 0; i < `BST_PIN_COUNT; i++) begin
				out_update[i] <= boundary_cell_chain[2*i+1];
			end
			upd_toggle <= ~upd_toggle;
		end
	end

	// Identity capture and shift
	always_ff @(posedge tck or posedge rst) begin
		if (rst) begin
			id_shift <= '0;
		end else if (sel_id && cap_dr) begin
			id_shift <= part_identity_word;
		end else if (sel_id && sh_dr) begin
			id_shift <= {tdi, id_shift[`BST_ID_LEN-1:1]};
		end
	end

	// Passthrough: captures zero, one stage in shift
	always_ff @(posedge tck or posedge rst) begin
		if (rst) begin
			passthrough_flop <= 1'h0;
		end else if (sel_bypass && cap_dr) begin
			passthrough_flop <= 1'h0;
		end else if (sel_bypass && sh_dr) begin
			passthrough_flop <= tdi;
		end
	end

	// ----------------------------------------
	// Serial output, falling edge
	// ----------------------------------------
	wire logic dr_serial = sel_chain ? boundary_cell_chain[0] :
		sel_id ? id_shift[0] : passthrough_flop;
	wire logic next_tdo = sh_ir ? ir_shift[0] : dr_serial;
	wire logic next_tdo_oe = sh_ir | sh_dr;

	// Present the serial bit half a test clock after the shift edge
	always_ff @(negedge tck or posedge rst) begin
		if (rst) begin
			tdo <= 1'h0;
			tdo_oe <= 1'h0;
		end else begin
			tdo <= next_tdo;
			tdo_oe <= next_tdo_oe;
		end
	end

	// ----------------------------------------
	// System clock domain: pins and core
	// ----------------------------------------
	logic drive_meta; // First stage, read only by drive_sync
	logic drive_sync; // Test drive mode on the system clock
	logic highz_meta; // First stage, read only by highz_sync
	logic highz_sync; // High-impedance mode on the system clock
	logic toggle_meta; // First stage, read only by toggle_sync
	logic toggle_sync; // Update toggle on the system clock
	logic toggle_seen; // Toggle value already acted upon
	logic [`BST_PIN_COUNT-1:0] upd_sync; // Out cell values on the system clock
	logic [`BST_PIN_COUNT-1:0] in_meta; // First stage, read only by core_in

	// Level crossings from the test clock and from the pins
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			drive_meta <= 1'h0;
			drive_sync <= 1'h0;
			highz_meta <= 1'h0;
			highz_sync <= 1'h0;
			toggle_meta <= 1'h0;
			toggle_sync <= 1'h0;
			toggle_seen <= 1'h0;
			upd_sync <= '0;
			in_meta <= '0;
			core_in <= '0;
		end else begin
			drive_meta <= drive_flag;
			drive_sync <= drive_meta;
			highz_meta <= highz_flag;
			highz_sync <= highz_meta;
			toggle_meta <= upd_toggle;
			toggle_sync <= toggle_meta;
			toggle_seen <= toggle_sync;
			// The out cell word has stood still for two system edges by now
			if (toggle_sync != toggle_seen) begin
				upd_sync <= out_update;
			end
			in_meta <= pin_in;
			core_in <= in_meta;
		end
	end

	// Pin drive selection
	wire logic [`BST_PIN_COUNT-1:0] next_pin_out = drive_sync ? upd_sync : core_out;
	wire logic [`BST_PIN_COUNT-1:0] next_pin_oe = highz_sync ? '0 :
		drive_sync ? '1 : core_oe;

	// Registered pin outputs
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pin_out <= '0;
			pin_oe <= '0;
		end else begin
			pin_out <= next_pin_out;
			pin_oe <= next_pin_oe;
		end
	end

endmodule : boundary_scan_tap

// File: verif/boundary_scan_tap_props.sv
// Concurrent checks on the test access port pins
`timescale 1ns/1ps
`include "boundary_scan_tap_consts.svh"
module boundary_scan_tap_props (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	input wire logic tdo,
	input wire logic tdo_oe,
	input wire logic [`BST_PIN_COUNT-1:0] core_out,
	input wire logic [`BST_PIN_COUNT-1:0] core_oe,
	input wire logic [`BST_PIN_COUNT-1:0] core_in,
	input wire logic [`BST_PIN_COUNT-1:0] pin_in,
	input wire logic [`BST_PIN_COUNT-1:0] pin_out,
	input wire logic [`BST_PIN_COUNT-1:0] pin_oe
);
	logic [2:0] hist; // Last three mode bits, newest in bit 0
	logic [2:0] ones; // Run of high mode bits, stops at 5
	logic [1:0] up; // System edges since reset release, stops at 3
	// Mode history on the test clock
	always_ff @(posedge tck or posedge rst) begin
		if (rst) begin
			hist <= 3'h0;
			ones <= 3'h0;
		end else begin
			hist <= {hist[1:0], tms};
			ones <= !tms ? 3'h0 : (ones == 3'h5 ? ones : ones + 3'h1);
		end
	end
	// Settling count after reset
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) up <= 2'h0;
		else if (up != 2'h3) up <= up + 2'h1;
	end
	rst_quiet_a: assert property (@(posedge clk_sys) rst |-> !tdo_oe && pin_oe == 4'h0)
		else $error("outputs active in reset");
	five_ones_a: assert property (@(posedge tck) disable iff (rst) ones == 3'h5 |-> !tdo_oe)
		else $error("five high mode bits did not reset");
	tdo_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
		tck && $past(tck) |-> $stable(tdo))
		else $error("serial out moved with test clock high");
	oe_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
		tck && $past(tck) |-> $stable(tdo_oe))
		else $error("serial enable moved with test clock high");
	core_in_a: assert property (@(posedge clk_sys) disable iff (rst)
		up == 2'h3 |-> core_in == $past(pin_in, 2))
		else $error("core input not pin after two flops");
	shift_entry_a: assert property (@(posedge tck) disable iff (rst)
		$rose(tdo_oe) |-> !hist[0] && (hist[1] || hist[2]))
		else $error("shift entered on a wrong mode path");
	shift_exit_a: assert property (@(posedge tck) disable iff (rst) $fell(tdo_oe) |-> hist[0])
		else $error("shift left with mode low");
	exit_settle_a: assert property (@(posedge tck) disable iff (rst) $fell(tdo_oe) |=> !tdo_oe)
		else $error("shift resumed straight after exit");
	cover property (@(posedge tck) $rose(tdo_oe));
	cover property (@(posedge tck) ones == 3'h5);
	cover property (@(posedge clk_sys) pin_oe == 4'hf);
endmodule : boundary_scan_tap_props

// File: verif/jtag_tester.sv
// Behavioural test controller that clocks frames into the port
`timescale 1ns/1ps
module jtag_tester (
	output logic tck,
	output logic tms,
	output logic tdi,
	input wire logic tdo
);
	int half = 32; // Half of the 64 ns test clock period
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
	end
	// One test clock, set with clock low, output taken at the rise
	task automatic step(input logic m, input logic d, output logic o);
		tms = m;
		tdi = d;
		#half;
		tck = 1'b1;
		o = tdo;
		#half;
		tck = 1'b0;
	endtask : step
	// Five high mode bits, then idle
	task automatic reset_tap();
		logic o;
		repeat (5) step(1'b1, ~tdi, o);
		step(1'b0, ~tdi, o);
	endtask : reset_tap
	// Full scan from idle back to idle, bit 0 first
	task automatic scan(input logic ir, input int n, input logic [31:0] din,
		output logic [31:0] dout);
		logic o;
		dout = 32'h0;
		step(1'b1, ~tdi, o);
		if (ir) step(1'b1, ~tdi, o);
		step(1'b0, ~tdi, o);
		step(1'b0, ~tdi, o);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], o);
			dout[i] = o;
		end
		step(1'b1, ~tdi, o);
		step(1'b0, ~tdi, o);
	endtask : scan
endmodule : jtag_tester

// File: verif/tb_top.sv
// Self-checking bench for the boundary-scan test access port
`timescale 1ns/1ps
`include "boundary_scan_tap_consts.svh"
module tb_top;
	logic clk_sys = 1'b0;
	logic rst = 1'b0;
	logic tck, tms, tdi, tdo, tdo_oe, o, tdo_line;
	logic [3:0] core_out = 4'h0, core_oe = 4'h0, pin_in = 4'h0;
	logic [3:0] core_in, pin_out, pin_oe, c, upd, msk, xo, xe;
	logic [31:0] dout, din, xp, id_word, held;
	logic [3:0] codes [7] = '{`BST_INS_SAMPLE, `BST_INS_EXTEST, `BST_INS_CLAMP,
		`BST_INS_HIGHZ, `BST_INS_IDCODE, `BST_INS_BYPASS, 4'h7};
	int failures = 0, cmp_count = 0;
	assign id_word = {`BST_ID_VERSION, `BST_ID_PART, `BST_ID_MAKER, `BST_ID_FIXED};
	always #2.5 clk_sys = ~clk_sys;
	boundary_scan_tap u_dut (.clk_sys(clk_sys), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi),
		.tdo(tdo), .tdo_oe(tdo_oe), .core_out(core_out), .core_oe(core_oe),
		.core_in(core_in), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
	// Tester sees the serial line through a pull-up while the port is not driving
	assign tdo_line = tdo_oe ? tdo : 1'b1;
	jtag_tester u_tst (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_line));
	task automatic chk_scan(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_scan
	task automatic chk_pins(input logic [11:0] got, input logic [11:0] exp);
		chk_scan({20'h0, got}, {20'h0, exp});
	endtask : chk_pins
	// Reference shift path: captured bits leave first, then the bits shifted in
	task automatic model_scan(input logic [31:0] cap, input int len, input logic [31:0] sin,
		output logic [31:0] sout, output logic [31:0] rest);
		logic q[$];
		for (int i = 0; i < len; i++) q.push_back(cap[i]);
		for (int i = 0; i < 32; i++) begin
			sout[i] = q.pop_front();
			q.push_back(sin[i]);
		end
		rest = 32'h0;
		foreach (q[i]) rest[i] = q[i];
	endtask : model_scan
	task automatic conclude();
		$display("comparisons=%0d failures=%0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : conclude
	// Cut a hang short
	initial begin
		#400000;
		failures++;
		conclude();
	end
	// Main sequence
	initial begin
		void'($urandom(32'he900f0d2));
		// Rising reset after time zero so every asynchronous reset branch fires
		rst <= 1'b1;
		repeat (10) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		u_tst.reset_tap();
		u_tst.scan(1'b0, 32, 32'h0, dout);
		chk_scan(dout, id_word);
		// Load bypass, stop in the middle of a data shift, escape by mode bits
		u_tst.scan(1'b1, 4, {28'h0, `BST_INS_BYPASS}, dout);
		u_tst.step(1'b1, 1'b0, o);
		repeat (5) u_tst.step(1'b0, 1'b1, o);
		u_tst.reset_tap();
		u_tst.scan(1'b0, 32, 32'h0, dout);
		chk_scan(dout, id_word);
		foreach (codes[k]) begin
			c = codes[k];
			@(posedge clk_sys);
			core_out <= 4'($urandom);
			core_oe <= 4'($urandom);
			pin_in <= 4'($urandom);
			u_tst.scan(1'b1, 4, {28'h0, c}, dout);
			chk_scan(dout, {28'h0, `BST_IR_CAPTURE});
			din = $urandom;
			u_tst.scan(1'b0, 32, din, dout);
			model_scan(32'h0, 1, din, xp, held);
			if (c == `BST_INS_IDCODE) model_scan(id_word, 32, din, xp, held);
			if (c <= `BST_INS_SAMPLE) begin
				model_scan({24'h0, core_out[3], pin_in[3], core_out[2], pin_in[2],
					core_out[1], pin_in[1], core_out[0], pin_in[0]}, 8, din, xp, held);
				upd = {held[7], held[5], held[3], held[1]};
			end
			chk_scan(dout, xp);
			repeat (6) @(posedge clk_sys);
			msk = 4'hf;
			{xe, xo} = {core_oe, core_out};
			if (c == `BST_INS_EXTEST || c == `BST_INS_CLAMP) {xe, xo} = {4'hf, upd};
			if (c == `BST_INS_HIGHZ) {xe, msk} = 8'h0;
			chk_pins({core_in, pin_oe, pin_out & msk}, {pin_in, xe, xo & msk});
		end
		conclude();
	end
endmodule : tb_top
bind boundary_scan_tap boundary_scan_tap_props u_props (.clk_sys(clk_sys), .rst(rst),
	.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .core_out(core_out),
	.core_oe(core_oe), .core_in(core_in), .pin_in(pin_in), .pin_out(pin_out),
	.pin_oe(pin_oe));
